// ---- verilog/csf_defines.svh ----
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH
// Register location: low seven address bits, same in every bank
`define CSF_ADDR_LOW 7'h03
`define CSF_ADDR_W 9
// Field positions
`define CSF_BIT_IND 7
`define CSF_BIT_DHI 6
`define CSF_BIT_DLO 5
`define CSF_BIT_WDX 4
`define CSF_BIT_PWD 3
`define CSF_BIT_Z 2
`define CSF_BIT_DC 1
`define CSF_BIT_C 0
// Reset value: bank bits zero, reset-cause flags one, arithmetic flags zero
`define CSF_RESET 8'h18
// Result byte that sets the zero flag when the ALU result matches it
`define CSF_ZERO_BYTE 8'h00
// Per-field power-up values, split from the whole-register value above
`define CSF_RESET_BANK 3'h0
`define CSF_RESET_WDX 1'b1
`define CSF_RESET_PWD 1'b1
`define CSF_RESET_Z 1'b0
`define CSF_RESET_DC 1'b0
`define CSF_RESET_C 1'b0
// Bank bits after a clear-file
`define CSF_BANK_CLEAR 3'h0
// Operand bit positions used by the adder, rotates and address decode
`define CSF_ADDR_LOW_MSB 6
`define CSF_NIB_MSB 3
`define CSF_NIB_CARRY 4
`define CSF_BYTE_MSB 7
`define CSF_BYTE_LSB 0
`define CSF_BYTE_CARRY 8
`endif

// ---- verilog/csf_pkg.sv ----
package csf_pkg;
    // ALU operation classes as seen by the flag logic
    typedef enum logic [7:0] {
        CSF_OP_NONE = 8'h01, // No flag effect (bit set/clear, swap, move, etc.)
        CSF_OP_ADD = 8'h02,  // Sets zero, digit carry, carry
        CSF_OP_SUB = 8'h04,  // Sets zero, digit borrow, borrow (inverted)
        CSF_OP_LOGIC = 8'h08, // Sets zero only
        CSF_OP_RLEFT = 8'h10, // Carry from top bit of source
        CSF_OP_RRIGHT = 8'h20, // Carry from bottom bit of source
        CSF_OP_CLEAR = 8'h40  // Clear-file: result zero, zero flag set
    } csf_op_e;

    // One executed instruction as handed over by the decoder and ALU
    typedef struct packed {
        logic valid;
        csf_op_e op;
        logic [7:0] opa;
        logic [7:0] opb;
        logic [7:0] result;
        logic wr_en;
        logic [8:0] wr_addr;
    } csf_instr_s;

    // Core events that steer the reset-cause flags
    typedef struct packed {
        logic watchdog_clear_instr;
        logic sleep_instr;
        logic watchdog_timer_expired;
    } csf_event_s;
endpackage : csf_pkg

// ---- verilog/csf_status_reg.sv ----
`timescale 1ns/100ps
`include "csf_defines.svh"
// Contract
// - Status register accepts any instruction's write to its bank bits; arithmetic flags take writes only from ops that set no flags.
// - Flag-affecting instruction writing status: zero, digit carry, carry come from flags.
// - Watchdog expiry and powerdown flags ignore every data write.
// - Clear-file on status clears bank bits, sets zero, keeps other flags.
// - Bit clear/set, nibble exchange, move-work-to-file leave arithmetic flags alone.
// - Subtraction carry and digit carry are inverted borrows.
// - Bit 7 gives upper address bit for indirect access.
// - Bits 6..5 select one of four 128-byte banks for direct access.
// - Watchdog expiry flag set by power-up, watchdog clear, sleep; cleared on expiry.
// - Powerdown flag set by power-up and watchdog clear; cleared by sleep.
// - Digit carry set on carry out of low nibble in add.
// - Rotates load carry with the bit shifted out of the source.
// - Register answers at the same offset in all four banks.
module csf_status_reg (
    input wire logic clock,
    input wire logic rst_b,
    input csf_pkg::csf_instr_s instr,
    input csf_pkg::csf_event_s evt,
    input wire logic [7:0] rd_data_file,
    input wire logic [6:0] rd_addr_low,
    output logic [7:0] rd_data,
    output logic [7:0] status_q,
    output logic indirect_bank_select,
    output logic [1:0] direct_bank_select
);
    // Address decode
    logic hit;
    logic rd_hit;

    // Shared adder and flag logic
    logic flag_op;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] addend;
    logic cin;
    logic z_new;
    logic dc_new;
    logic c_new;
    logic upd_z;
    logic upd_dc;
    logic upd_c;

    // Write steering
    logic is_clear;
    logic wr_bank;
    logic wr_arith;
    logic [2:0] wr_bank_val;

    // One register per field group
    logic [2:0] bank_q;
    logic wdx_q;
    logic pwd_q;
    logic zero_q;
    logic dc_q;
    logic carry_q;

    // Any bank reaches the register: only the low seven address bits are decoded
    assign hit = instr.valid && instr.wr_en
        && (instr.wr_addr[`CSF_ADDR_LOW_MSB:0] == `CSF_ADDR_LOW);
    // Reads decode the same low bits, so every mirror answers
    assign rd_hit = (rd_addr_low == `CSF_ADDR_LOW);

    // Adder shared by add and subtract; subtract adds the two's complement
    always_comb begin
        addend = instr.opb;
        cin = 1'b0;
        if (instr.op == csf_pkg::CSF_OP_SUB) begin
            addend = ~instr.opb;
            cin = 1'b1;
        end
        sum = {1'b0, instr.opa} + {1'b0, addend} + {8'h00, cin};
        nib = {1'b0, instr.opa[`CSF_NIB_MSB:0]} + {1'b0, addend[`CSF_NIB_MSB:0]} + {4'h0, cin};
    end

    // Flag values and which flags this operation touches
    always_comb begin
        z_new = (instr.result == `CSF_ZERO_BYTE);
        dc_new = nib[`CSF_NIB_CARRY];
        c_new = sum[`CSF_BYTE_CARRY];
        upd_z = 1'b0;
        upd_dc = 1'b0;
        upd_c = 1'b0;
        case (instr.op)
            csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_SUB: begin
                upd_z = 1'b1;
                upd_dc = 1'b1;
                upd_c = 1'b1;
            end
            csf_pkg::CSF_OP_LOGIC: begin
                upd_z = 1'b1;
            end
            csf_pkg::CSF_OP_CLEAR: begin
                upd_z = 1'b1;
                z_new = 1'b1;
            end
            csf_pkg::CSF_OP_RLEFT: begin
                upd_c = 1'b1;
                c_new = instr.opa[`CSF_BYTE_MSB];
            end
            csf_pkg::CSF_OP_RRIGHT: begin
                upd_c = 1'b1;
                c_new = instr.opa[`CSF_BYTE_LSB];
            end
            default: begin
                // No flag effect for plain moves, bit ops and swaps
            end
        endcase
        flag_op = upd_z || upd_dc || upd_c;
    end

    // Clear-file decode for the bank bits only; the case above decodes it again to set the zero flag through z_new
    assign is_clear = instr.valid && (instr.op == csf_pkg::CSF_OP_CLEAR);

    // Bank bits take every data write aimed at the register
    assign wr_bank = hit;
    // Arithmetic bits take a data write only from ops that set no flags
    assign wr_arith = hit && !flag_op;
    // Forced to zero on clear-file, so a stray ALU result cannot move the banks
    assign wr_bank_val = is_clear ? `CSF_BANK_CLEAR
        : instr.result[`CSF_BIT_IND:`CSF_BIT_DLO];

    // Bank select bits: plain storage, power-up in bank 0
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bank_q <= `CSF_RESET_BANK;
        end else begin
            if (wr_bank) begin
                bank_q <= wr_bank_val;
            end
        end
    end

    // Expiry flag: events only, data has no path in; a time-out beats a same-cycle set
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wdx_q <= `CSF_RESET_WDX;
        end else begin
            if (evt.watchdog_timer_expired) begin
                wdx_q <= 1'b0;
            end else if (evt.watchdog_clear_instr || evt.sleep_instr) begin
                wdx_q <= 1'b1;
            end
        end
    end

    // Powerdown flag: events only; sleep beats a same-cycle watchdog clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pwd_q <= `CSF_RESET_PWD;
        end else begin
            if (evt.sleep_instr) begin
                pwd_q <= 1'b0;
            end else if (evt.watchdog_clear_instr) begin
                pwd_q <= 1'b1;
            end
        end
    end

    // Zero flag: flag logic wins over a data write aimed at the register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            zero_q <= `CSF_RESET_Z;
        end else begin
            if (instr.valid && upd_z) begin
                zero_q <= z_new;
            end else if (wr_arith) begin
                zero_q <= instr.result[`CSF_BIT_Z];
            end
        end
    end

    // Digit carry: add and subtract set it; otherwise only a data write from an op that sets no flags moves it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dc_q <= `CSF_RESET_DC;
        end else begin
            if (instr.valid && upd_dc) begin
                dc_q <= dc_new;
            end else if (wr_arith) begin
                dc_q <= instr.result[`CSF_BIT_DC];
            end
        end
    end

    // Carry: add, subtract and rotates move it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            carry_q <= `CSF_RESET_C;
        end else begin
            if (instr.valid && upd_c) begin
                carry_q <= c_new;
            end else if (wr_arith) begin
                carry_q <= instr.result[`CSF_BIT_C];
            end
        end
    end

    // Register image; the field defines fix the bit order
    always_comb begin
        status_q[`CSF_BIT_IND:`CSF_BIT_DLO] = bank_q;
        status_q[`CSF_BIT_WDX] = wdx_q;
        status_q[`CSF_BIT_PWD] = pwd_q;
        status_q[`CSF_BIT_Z] = zero_q;
        status_q[`CSF_BIT_DC] = dc_q;
        status_q[`CSF_BIT_C] = carry_q;
    end

    // Bank select taps for the address path
    assign indirect_bank_select = status_q[`CSF_BIT_IND];
    assign direct_bank_select = {status_q[`CSF_BIT_DHI], status_q[`CSF_BIT_DLO]};

    // Read mux: the status register wins at its mirrored location
    always_comb begin
        if (rd_hit) begin
            rd_data = status_q;
        end else begin
            rd_data = rd_data_file;
        end
    end
endmodule : csf_status_reg

// ---- tb/csf_status_reg_properties.sv ----
`timescale 1ns/100ps
// Flag and bank checks seen from the status register ports
module csf_status_reg_properties (
    input wire logic clock,
    input wire logic rst_b,
    input csf_pkg::csf_instr_s instr,
    input csf_pkg::csf_event_s evt,
    input wire logic [6:0] rd_addr_low,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] status_q,
    input wire logic indirect_bank_select
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Reference carries; an inverted borrow is the carry of opa + ~opb + 1
    logic [8:0] add_s, sub_s;
    logic [4:0] add_n, sub_n;
    logic hit;
    assign add_s = {1'b0, instr.opa} + {1'b0, instr.opb};
    assign sub_s = {1'b0, instr.opa} + {1'b0, ~instr.opb} + 9'h001;
    assign add_n = {1'b0, instr.opa[3:0]} + {1'b0, instr.opb[3:0]};
    assign sub_n = {1'b0, instr.opa[3:0]} + {1'b0, ~instr.opb[3:0]} + 5'h01;
    assign hit = instr.valid && instr.wr_en && instr.wr_addr[6:0] == 7'h03;
    a_cause_hold: assert property (evt == '0 |=> status_q[4:3] == $past(status_q[4:3]))
        else $error("cause flags moved");
    a_expiry_clear: assert property (evt.watchdog_timer_expired |=> !status_q[4])
        else $error("expiry flag not cleared");
    a_sleep_clear: assert property (evt.sleep_instr |=> !status_q[3])
        else $error("powerdown flag not cleared");
    a_clear_file: assert property (hit && instr.op == csf_pkg::CSF_OP_CLEAR |=>
        status_q[7:5] == 3'h0 && status_q[2] && status_q[1:0] == $past(status_q[1:0]))
        else $error("clear result wrong");
    a_add_flags: assert property (instr.valid && instr.op == csf_pkg::CSF_OP_ADD |=>
        status_q[2:0] == {$past(instr.result) == 8'h00, $past(add_n[4]), $past(add_s[8])})
        else $error("add flags wrong");
    a_sub_borrow: assert property (instr.valid && instr.op == csf_pkg::CSF_OP_SUB |=>
        status_q[1:0] == {$past(sub_n[4]), $past(sub_s[8])}) else $error("borrow wrong");
    a_rotate_carry: assert property (instr.valid && instr.op == csf_pkg::CSF_OP_RLEFT |=>
        status_q[0] == $past(instr.opa[7])) else $error("rotate carry wrong");
    a_rotate_right: assert property (instr.valid && instr.op == csf_pkg::CSF_OP_RRIGHT |=>
        status_q[0] == $past(instr.opa[0])) else $error("right rotate carry wrong");
    a_mirror_read: assert property (rd_addr_low == 7'h03 |-> rd_data == status_q
        && indirect_bank_select == status_q[7]) else $error("mirror read wrong");
    c_clear: cover property (hit && instr.op == csf_pkg::CSF_OP_CLEAR);
    c_sub: cover property (hit && instr.op == csf_pkg::CSF_OP_SUB);
    c_sleep: cover property (evt.sleep_instr);
endmodule : csf_status_reg_properties

// ---- tb/csf_status_reg_bench.sv ----
`timescale 1ns/100ps
module csf_status_reg_bench;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic ind_bank;
    logic [1:0] dir_bank;
    logic [6:0] rd_addr_low = 7'h00;
    logic [7:0] rd_data_file = 8'h00, rd_data, status_q, exp_q;
    csf_pkg::csf_instr_s instr = '0;
    csf_pkg::csf_event_s evt = '0;
    csf_pkg::csf_op_e op;
    int num_errors = 0, num_checks = 0;
    always #12.5 clock = ~clock;
    csf_status_reg DUT (.clock(clock), .rst_b(rst_b), .instr(instr), .evt(evt),
        .rd_data_file(rd_data_file), .rd_addr_low(rd_addr_low), .rd_data(rd_data),
        .status_q(status_q), .indirect_bank_select(ind_bank), .direct_bank_select(dir_bank));
    // Expected register after one edge; later events win, as the design chose
    function automatic logic [7:0] nxt(logic [7:0] s, csf_pkg::csf_instr_s i,
            csf_pkg::csf_event_s e);
        if (i.valid && i.wr_en && i.wr_addr[6:0] == 7'h03) begin
            s[7:5] = (i.op == csf_pkg::CSF_OP_CLEAR) ? 3'h0 : i.result[7:5];
            s[2:0] = (i.op == csf_pkg::CSF_OP_NONE) ? i.result[2:0] : s[2:0];
        end
        case (i.valid ? i.op : csf_pkg::CSF_OP_NONE)
            csf_pkg::CSF_OP_ADD: s[2:0] = {i.result == 8'h00,
                {1'b0, i.opa[3:0]} + {1'b0, i.opb[3:0]} > 5'h0f,
                {1'b0, i.opa} + {1'b0, i.opb} > 9'h0ff};
            csf_pkg::CSF_OP_SUB: s[2:0] = {i.result == 8'h00,
                i.opa[3:0] >= i.opb[3:0], i.opa >= i.opb};
            csf_pkg::CSF_OP_LOGIC: s[2] = i.result == 8'h00;
            csf_pkg::CSF_OP_CLEAR: s[2] = 1'b1;
            csf_pkg::CSF_OP_RLEFT: s[0] = i.opa[7];
            csf_pkg::CSF_OP_RRIGHT: s[0] = i.opa[0];
            default: ;
        endcase
        if (e.watchdog_clear_instr) s[4:3] = 2'b11;
        if (e.sleep_instr) s[4:3] = 2'b10;
        if (e.watchdog_timer_expired) s[4] = 1'b0;
        return s;
    endfunction : nxt
    // Reference register, reset like the design
    always @(posedge clock or negedge rst_b)
        if (!rst_b) exp_q <= 8'h18;
        else exp_q <= nxt(exp_q, instr, evt);
    task automatic chk(string name, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    // Runs take about 26 us; cut a hang well after that
    initial begin
        #40000;
        num_errors++;
        give_verdict();
    end
    // Two resets; first 28 steps walk every op into every bank, at the register only when k % 3 is nonzero, then random
    initial begin
        void'($urandom(32'h1c1ff61a));
        for (int r = 0; r < 2; r++) begin
            rst_b <= 1'b0;
            instr <= '0;
            evt <= '0;
            repeat (16) @(posedge clock);
            chk("reset", 8'h18, status_q);
            rst_b <= 1'b1;
            for (int k = 0; k < 500; k++) begin
                op = csf_pkg::csf_op_e'(8'h01 << (k < 28 ? k % 7 : $urandom % 7));
                instr <= '{1'b1, op, (k % 2) ? 8'h0f : 8'($urandom),
                    (k % 3) ? 8'h01 : 8'($urandom),
                    (op == csf_pkg::CSF_OP_CLEAR || k % 4 == 0) ? 8'h00 : 8'($urandom),
                    k < 28 || $urandom % 2, {2'(k), k % 3 ? 7'h03 : 7'($urandom)}};
                evt <= 3'(k % 6 == 0 ? $urandom : 0);
                rd_addr_low <= k % 3 ? 7'h03 : 7'($urandom);
                rd_data_file <= 8'($urandom);
                @(negedge clock);
                chk("status", exp_q, status_q);
                chk("read", rd_addr_low == 7'h03 ? exp_q : rd_data_file, rd_data);
                chk("banks", {5'h00, exp_q[7:5]}, {5'h00, ind_bank, dir_bank});
                @(posedge clock);
            end
            $display("test %0d done", r);
        end
        give_verdict();
    end
endmodule : csf_status_reg_bench
bind csf_status_reg csf_status_reg_properties u_props (.clock(clock), .rst_b(rst_b),
    .instr(instr), .evt(evt), .rd_addr_low(rd_addr_low), .rd_data(rd_data),
    .status_q(status_q), .indirect_bank_select(indirect_bank_select));
